/* rtl/tac_pkg.sv */
// Purpose: Shared constants for the trapezoidal algorithm configuration bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Printed offsets are word indices; byte address is four times each

package tac_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [9:0]  PROFILE_IDX      = 10'h098;
  localparam logic [9:0]  CFG_ONE_IDX      = 10'h09A;
  localparam logic [11:0] PROFILE_ADDR     = {PROFILE_IDX, 2'b00};
  localparam logic [11:0] CFG_ONE_ADDR     = {CFG_ONE_IDX, 2'b00};
  localparam logic [31:0] PROFILE_RESET    = 32'h00000000;
  localparam logic [31:0] CFG_ONE_RESET    = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ    = 32'h00000000;

  // ****************************************************************
  // Profile field positions (least significant bit of each), step count and step stride
  // ****************************************************************
  localparam int STEP_COUNT     = 5;
  localparam int STEP3_LSB      = 19;
  localparam int STEP_STRIDE    = 3;
  localparam int ADVANCE_LSB    = 5;
  localparam int PARITY_BIT     = 31;

  // ****************************************************************
  // Config-one field positions
  // ****************************************************************
  localparam int HANDOVER_LSB   = 22;
  localparam int NEG_LIMIT_LSB  = 16;
  localparam int HYST_BIT       = 15;
  localparam int BEMF_LSB       = 10;
  localparam int CYCLE_LSB      = 7;
  localparam int XANGLE_LSB     = 2;
  localparam int DIVIDER_LSB    = 0;

  // ****************************************************************
  // Decoded value scales
  // ****************************************************************
  localparam logic [12:0] BEMF_STEP     = 13'h00C8;
  localparam logic [4:0]  CYCLE_BASE    = 5'h02;
  localparam logic [4:0]  CYCLE_STEP    = 5'h03;
  localparam logic [3:0]  ADVANCE_STEP  = 4'h5;

endpackage

/* rtl/tac_cfg_if.sv */
// Purpose: Carries stored words and decoded values between bank and decoder
// Assumes: Single clock domain, purely combinational decode
// Notes:   Duty values are in hundredths of a percent

`timescale 1ns/100ps
`default_nettype none

interface tac_cfg_if;
  logic               [31:0] profile;
  logic               [31:0] config_one;
  logic               [13:0] duty [tac_pkg::STEP_COUNT];
  logic               [3:0]  advance;
  logic signed        [7:0]  neg_limit;
  logic signed        [7:0]  pos_limit;
  logic               [4:0]  hysteresis;
  logic               [12:0] bemf;
  logic               [4:0]  cycles;
  logic               [3:0]  xangle;
  logic               [3:0]  divider;

  modport bank (output profile, config_one,
                input  duty, advance, neg_limit, pos_limit, hysteresis,
                       bemf, cycles, xangle, divider);
  modport dec  (input  profile, config_one,
                output duty, advance, neg_limit, pos_limit, hysteresis,
                       bemf, cycles, xangle, divider);
endinterface // tac_cfg_if

`default_nettype wire

/* rtl/tac_field_decode.sv */
// Purpose: Turns stored field codes into the values the algorithm uses
// Assumes: Codes come from the register bank over the carrier interface
// Notes:   Combinational; the bank registers every result

`timescale 1ns/100ps
`default_nettype none

module tac_field_decode (
  tac_cfg_if.dec cfg  // Stored words in, decoded values out
);

  function automatic logic [13:0] duty_of(input logic [2:0] code);
    case (code)
      3'h0:    duty_of = 14'h0000;
      3'h1:    duty_of = 14'h1388;
      3'h2:    duty_of = 14'h1D4C;
      3'h3:    duty_of = 14'h20B7;
      3'h4:    duty_of = 14'h222E;
      3'h5:    duty_of = 14'h249F;
      3'h6:    duty_of = 14'h2616;
      default: duty_of = 14'h26AC;
    endcase
  endfunction

  function automatic logic signed [7:0] neg_of(input logic [2:0] code);
    case (code)
      3'h0:    neg_of = 8'sh00;
      3'h1:    neg_of = -8'sh28;
      3'h2:    neg_of = -8'sh1E;
      3'h3:    neg_of = -8'sh14;
      3'h4:    neg_of = -8'sh0A;
      3'h5:    neg_of = 8'sh0A;
      3'h6:    neg_of = 8'sh14;
      default: neg_of = 8'sh1E;
    endcase
  endfunction

  function automatic logic [3:0] xangle_of(input logic [1:0] code);
    case (code)
      2'h0:    xangle_of = 4'h5;
      2'h1:    xangle_of = 4'h8;
      2'h2:    xangle_of = 4'hC;
      default: xangle_of = 4'hF;
    endcase
  endfunction

  // ****************************************************************
  // Duty steps 3 to 7
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < tac_pkg::STEP_COUNT; i++) begin : g_step
      assign cfg.duty[i] = duty_of(
        cfg.profile[tac_pkg::STEP3_LSB - tac_pkg::STEP_STRIDE*i +: 3]);
    end
  endgenerate

  assign cfg.advance = 4'(cfg.profile[tac_pkg::ADVANCE_LSB +: 2]) * tac_pkg::ADVANCE_STEP;

  // ****************************************************************
  // Surge guard and start-up values
  // ****************************************************************
  wire logic [4:0] hyst_val = cfg.config_one[tac_pkg::HYST_BIT] ? 5'h0A : 5'h14;

  assign cfg.neg_limit  = neg_of(cfg.config_one[tac_pkg::NEG_LIMIT_LSB +: 3]);
  assign cfg.hysteresis = hyst_val;
  assign cfg.pos_limit  = cfg.neg_limit + $signed({3'h0, hyst_val});
  assign cfg.bemf    = 13'(cfg.config_one[tac_pkg::BEMF_LSB +: 5]) * tac_pkg::BEMF_STEP;
  assign cfg.cycles  = tac_pkg::CYCLE_BASE
                       + 5'(cfg.config_one[tac_pkg::CYCLE_LSB +: 3]) * tac_pkg::CYCLE_STEP;
  assign cfg.xangle  = xangle_of(cfg.config_one[tac_pkg::XANGLE_LSB +: 2]);
  // divider is a power of two
  assign cfg.divider = 4'h1 << cfg.config_one[tac_pkg::DIVIDER_LSB +: 2];

endmodule // tac_field_decode

`default_nettype wire

/* rtl/tac_config_bank.sv */
// Purpose: APB register bank for the duty profile and algorithm config one
// Assumes: APB master on CLK; no wait states, ready in the first access cycle
// Notes:   Decoded outputs trail the stored words by one clock
// Notes on behaviour
// - Profile bits 21..19 hold the step-3 duty code on the eight-level duty scale.
// - Profile bits 18..16 hold the step-4 duty code on the same duty scale.
// - Profile bits 15..13, 12..10 and 9..7 hold steps 5, 6 and 7 on the same scale.
// - Profile bits 6..5 select a lead advance of 0, 5, 10 or 15 degrees.
// - Config one sits at index 9Ah and resets to all zeros.
// - Config one bits 18..16 give the surge negative limit 0,-40,-30,-20,-10,10,20,30.
// - Config one bit 15 gives hysteresis 20 or 10; positive limit is hysteresis plus negative.
// - Config one bits 14..10 times 200 give the back-EMF threshold.
// - Config one bits 9..7 give 2, 5, 8 .. 23 detect cycles.
// - Config one bits 3..2 give the open-loop crossing angle 5, 8, 12 or 15 degrees.
// - Config one bits 1..0 give a start-up rate divider of 1, 2, 4 or 8.
// - The profile sits at index 98h and resets to all zeros.
//
// Design decision made here: register access over APB.

`timescale 1ns/100ps
`default_nettype none

module tac_config_bank (
  input  wire logic               CLK,                             // Core clock, 125 MHz
  input  wire logic               RESETN,                          // Async reset, low
  input  wire logic               PSEL,                            // APB select
  input  wire logic               PENABLE,                         // APB access phase
  input  wire logic               PWRITE,                          // APB write
  input  wire logic        [11:0] PADDR,                           // APB byte address
  input  wire logic        [31:0] PWDATA,                          // APB write data
  input  wire logic        [3:0]  PSTRB,                           // APB byte strobes
  output var  logic        [31:0] PRDATA,                          // APB read data
  output var  logic               PREADY,                          // APB ready
  output var  logic               PSLVERR,                         // APB error
  output var  logic        [13:0] TRI_DUTY_S3,                     // Step 3 duty, 0.01 %
  output var  logic        [13:0] TRI_DUTY_S4,                     // Step 4 duty, 0.01 %
  output var  logic        [13:0] TRI_DUTY_S5,                     // Step 5 duty, 0.01 %
  output var  logic        [13:0] TRI_DUTY_S6,                     // Step 6 duty, 0.01 %
  output var  logic        [13:0] TRI_DUTY_S7,                     // Step 7 duty, 0.01 %
  output var  logic        [3:0]  WIDE_MOD_ANGLE_ADVANCE,          // Advance, degrees
  output var  logic        [1:0]  OPEN_LOOP_HANDOVER_COUNT,        // Raw handover code
  output var  logic signed [7:0]  SURGE_GUARD_NEGATIVE_LIMIT,      // Negative limit value
  output var  logic signed [7:0]  SURGE_GUARD_POSITIVE_LIMIT,      // Positive limit value
  output var  logic        [4:0]  SURGE_GUARD_HYSTERESIS,          // Hysteresis value
  output var  logic        [12:0] INITIAL_SPEED_BACKEMF_THRESHOLD, // Back-EMF threshold
  output var  logic        [4:0]  INITIAL_SPEED_CYCLE_THRESHOLD,   // Detect cycles
  output var  logic        [3:0]  OPEN_LOOP_CROSSING_ANGLE,        // Angle, degrees
  output var  logic        [3:0]  QUICK_LAUNCH_RATE_DIVIDER        // Rate divider
);

  // ****************************************************************
  // Stored words and decoder
  // ****************************************************************
  tac_cfg_if cfg ();

  logic [31:0] profile;
  logic [31:0] config_one;

  assign cfg.profile    = profile;
  assign cfg.config_one = config_one;

  tac_field_decode u_decode (
    .cfg (cfg.dec)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic        setup_phase = PSEL & ~PENABLE;
  wire logic        access_done = PSEL & PENABLE & PREADY;
  wire logic        hit_profile = (PADDR == tac_pkg::PROFILE_ADDR);
  wire logic        hit_cfg_one = (PADDR == tac_pkg::CFG_ONE_ADDR);
  wire logic        mapped      = hit_profile | hit_cfg_one;
  wire logic        wr_profile  = access_done & PWRITE & hit_profile;
  wire logic        wr_cfg_one  = access_done & PWRITE & hit_cfg_one;
  wire logic [31:0] wmask       = {{8{PSTRB[3]}}, {8{PSTRB[2]}},
                                   {8{PSTRB[1]}}, {8{PSTRB[0]}}};

  wire logic [31:0] next_profile    = (profile & ~wmask) | (PWDATA & wmask);
  wire logic [31:0] next_config_one = (config_one & ~wmask) | (PWDATA & wmask);

  wire logic [31:0] read_word = hit_profile ? profile
                              : hit_cfg_one ? config_one
                              : tac_pkg::UNMAPPED_READ;

  // ****************************************************************
  // Registers
  // ****************************************************************
  // profile word, zero at reset
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      profile <= tac_pkg::PROFILE_RESET;
    end else if (wr_profile) begin
      profile <= next_profile;
    end
  end

  // config one word, zero at reset
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      config_one <= tac_pkg::CFG_ONE_RESET;
    end else if (wr_cfg_one) begin
      config_one <= next_config_one;
    end
  end

  // No wait state: ready and read data are prepared in the setup cycle
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= setup_phase;
      PSLVERR <= setup_phase & ~mapped;
      PRDATA  <= (setup_phase & ~PWRITE) ? read_word : 32'h00000000;
    end
  end

  // ****************************************************************
  // Registered decoded outputs and the raw handover code
  // ****************************************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      TRI_DUTY_S3                     <= 14'h0000;
      TRI_DUTY_S4                     <= 14'h0000;
      TRI_DUTY_S5                     <= 14'h0000;
      TRI_DUTY_S6                     <= 14'h0000;
      TRI_DUTY_S7                     <= 14'h0000;
      WIDE_MOD_ANGLE_ADVANCE          <= 4'h0;
      OPEN_LOOP_HANDOVER_COUNT        <= 2'h0;
      SURGE_GUARD_NEGATIVE_LIMIT      <= 8'sh00;
      SURGE_GUARD_POSITIVE_LIMIT      <= 8'sh14;
      SURGE_GUARD_HYSTERESIS          <= 5'h14;
      INITIAL_SPEED_BACKEMF_THRESHOLD <= 13'h0000;
      INITIAL_SPEED_CYCLE_THRESHOLD   <= 5'h02;
      OPEN_LOOP_CROSSING_ANGLE        <= 4'h5;
      QUICK_LAUNCH_RATE_DIVIDER       <= 4'h1;
    end else begin
      TRI_DUTY_S3                     <= cfg.duty[0];
      TRI_DUTY_S4                     <= cfg.duty[1];
      TRI_DUTY_S5                     <= cfg.duty[2];
      TRI_DUTY_S6                     <= cfg.duty[3];
      TRI_DUTY_S7                     <= cfg.duty[4];
      WIDE_MOD_ANGLE_ADVANCE          <= cfg.advance;
      OPEN_LOOP_HANDOVER_COUNT        <= config_one[tac_pkg::HANDOVER_LSB +: 2];
      SURGE_GUARD_NEGATIVE_LIMIT      <= cfg.neg_limit;
      SURGE_GUARD_POSITIVE_LIMIT      <= cfg.pos_limit;
      SURGE_GUARD_HYSTERESIS          <= cfg.hysteresis;
      INITIAL_SPEED_BACKEMF_THRESHOLD <= cfg.bemf;
      INITIAL_SPEED_CYCLE_THRESHOLD   <= cfg.cycles;
      OPEN_LOOP_CROSSING_ANGLE        <= cfg.xangle;
      QUICK_LAUNCH_RATE_DIVIDER       <= cfg.divider;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_step3_duty;
    @(posedge CLK) disable iff (!RESETN)
    profile[21:19] == 3'h3 |=> TRI_DUTY_S3 == 14'h20B7;
  endproperty
  a_step3_duty: assert property (p_step3_duty)
    else $error("step 3 duty decode wrong");

  property p_step4_duty;
    @(posedge CLK) disable iff (!RESETN)
    profile[18:16] == 3'h7 |=> TRI_DUTY_S4 == 14'h26AC;
  endproperty
  a_step4_duty: assert property (p_step4_duty)
    else $error("step 4 duty decode wrong");

  property p_step7_duty;
    @(posedge CLK) disable iff (!RESETN)
    profile[9:7] == 3'h1 && profile[15:13] == 3'h7
      |=> TRI_DUTY_S7 == 14'h1388 && TRI_DUTY_S5 == 14'h26AC;
  endproperty
  a_step7_duty: assert property (p_step7_duty)
    else $error("step 5 or 7 duty decode wrong");

  property p_advance;
    @(posedge CLK) disable iff (!RESETN)
    profile[6:5] == 2'h3 |=> WIDE_MOD_ANGLE_ADVANCE == 4'hF;
  endproperty
  a_advance: assert property (p_advance)
    else $error("angle advance decode wrong");

  property p_cfg_readback;
    @(posedge CLK) disable iff (!RESETN)
    setup_phase && !PWRITE && PADDR == tac_pkg::CFG_ONE_ADDR
      |=> PREADY && !PSLVERR && PRDATA == $past(config_one);
  endproperty
  a_cfg_readback: assert property (p_cfg_readback)
    else $error("config one readback wrong");

  property p_neg_limit;
    @(posedge CLK) disable iff (!RESETN)
    config_one[18:16] == 3'h1 |=> SURGE_GUARD_NEGATIVE_LIMIT == -8'sh28;
  endproperty
  a_neg_limit: assert property (p_neg_limit)
    else $error("surge negative limit wrong");

  property p_pos_limit;
    @(posedge CLK) disable iff (!RESETN)
    config_one[18:15] == 4'h0 ##1 config_one[18:15] == 4'h0
      |-> SURGE_GUARD_POSITIVE_LIMIT == 8'sh14 && SURGE_GUARD_HYSTERESIS == 5'h14;
  endproperty
  a_pos_limit: assert property (p_pos_limit)
    else $error("surge positive limit wrong");

  property p_bemf;
    @(posedge CLK) disable iff (!RESETN)
    config_one[14:10] == 5'h1F |=> INITIAL_SPEED_BACKEMF_THRESHOLD == 13'h1838;
  endproperty
  a_bemf: assert property (p_bemf)
    else $error("back-EMF threshold wrong");

  property p_cycles;
    @(posedge CLK) disable iff (!RESETN)
    config_one[9:7] == 3'h7 |=> INITIAL_SPEED_CYCLE_THRESHOLD == 5'h17;
  endproperty
  a_cycles: assert property (p_cycles)
    else $error("cycle threshold wrong");

  property p_xangle;
    @(posedge CLK) disable iff (!RESETN)
    config_one[3:2] == 2'h2 |=> OPEN_LOOP_CROSSING_ANGLE == 4'hC;
  endproperty
  a_xangle: assert property (p_xangle)
    else $error("crossing angle wrong");

  property p_divider;
    @(posedge CLK) disable iff (!RESETN)
    config_one[1:0] == 2'h3 |=> QUICK_LAUNCH_RATE_DIVIDER == 4'h8;
  endproperty
  a_divider: assert property (p_divider)
    else $error("rate divider wrong");

  property p_profile_write;
    @(posedge CLK) disable iff (!RESETN)
    access_done && PWRITE && PADDR == tac_pkg::PROFILE_ADDR && PSTRB == 4'hF
      |=> profile == $past(PWDATA);
  endproperty
  a_profile_write: assert property (p_profile_write)
    else $error("profile write not stored");

  property p_cfg_hold;
    @(posedge CLK) disable iff (!RESETN)
    !(access_done && PWRITE && PADDR == tac_pkg::CFG_ONE_ADDR)
      |=> config_one == $past(config_one);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("config one changed without write");

  property p_parity_bit;
    @(posedge CLK) disable iff (!RESETN)
    wr_cfg_one && PSTRB[3] |=> config_one[31] == $past(PWDATA[31]);
  endproperty
  a_parity_bit: assert property (p_parity_bit)
    else $error("top bit not writable");

  property p_unmapped;
    @(posedge CLK) disable iff (!RESETN)
    setup_phase && !mapped |=> PSLVERR && PREADY && PRDATA == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged");

  property p_step6_duty;
    @(posedge CLK) disable iff (!RESETN)
    profile[12:10] == 3'h5 |=> TRI_DUTY_S6 == 14'h249F;
  endproperty
  a_step6_duty: assert property (p_step6_duty)
    else $error("step 6 duty decode wrong");

  property p_pos_limit_low_hyst;
    @(posedge CLK) disable iff (!RESETN)
    config_one[18:15] == 4'hB
      |=> SURGE_GUARD_POSITIVE_LIMIT == 8'sh14 && SURGE_GUARD_HYSTERESIS == 5'h0A;
  endproperty
  a_pos_limit_low_hyst: assert property (p_pos_limit_low_hyst)
    else $error("low hysteresis limit wrong");

  property p_neg_limit_top;
    @(posedge CLK) disable iff (!RESETN)
    config_one[18:16] == 3'h7 |=> SURGE_GUARD_NEGATIVE_LIMIT == 8'sh1E;
  endproperty
  a_neg_limit_top: assert property (p_neg_limit_top)
    else $error("top negative limit wrong");

  property p_handover;
    @(posedge CLK) disable iff (!RESETN)
    config_one[23:22] == 2'h3 |=> OPEN_LOOP_HANDOVER_COUNT == 2'h3;
  endproperty
  a_handover: assert property (p_handover)
    else $error("handover code not passed");

  property p_divider_one;
    @(posedge CLK) disable iff (!RESETN)
    config_one[1:0] == 2'h0 |=> QUICK_LAUNCH_RATE_DIVIDER == 4'h1;
  endproperty
  a_divider_one: assert property (p_divider_one)
    else $error("unit divider wrong");

  property p_cfg_write;
    @(posedge CLK) disable iff (!RESETN)
    wr_cfg_one && PSTRB == 4'hF |=> config_one == $past(PWDATA);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("config one write not stored");

  property p_profile_hold;
    @(posedge CLK) disable iff (!RESETN)
    !wr_profile |=> profile == $past(profile);
  endproperty
  a_profile_hold: assert property (p_profile_hold)
    else $error("profile changed without write");

  property p_empty_strobe;
    @(posedge CLK) disable iff (!RESETN)
    access_done && PWRITE && PSTRB == 4'h0
      |=> profile == $past(profile) && config_one == $past(config_one);
  endproperty
  a_empty_strobe: assert property (p_empty_strobe)
    else $error("empty strobe changed a word");

  property p_ready_pulse;
    @(posedge CLK) disable iff (!RESETN)
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held too long");

  property p_err_only_ready;
    @(posedge CLK) disable iff (!RESETN)
    PSLVERR |-> PREADY;
  endproperty
  a_err_only_ready: assert property (p_err_only_ready)
    else $error("error without ready");

  property p_rdata_idle;
    @(posedge CLK) disable iff (!RESETN)
    !PREADY |-> PRDATA == 32'h00000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside access");

endmodule // tac_config_bank

`default_nettype wire

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the algorithm configuration bank
// Assumes: APB slave on CLK; decoded outputs trail the stored word by a clock
// Notes:   Step codes differ per field so swapped or shifted fields show up

`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic               CLK;
  logic               RESETN;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic        [11:0] paddr;
  logic        [31:0] pwdata;
  logic        [3:0]  pstrb;
  logic        [31:0] PRDATA;
  logic               PREADY;
  logic               PSLVERR;
  logic        [13:0] duty [5];
  logic        [3:0]  adv, angle, divider;
  logic        [1:0]  handover;
  logic signed [7:0]  neg, pos;
  logic        [4:0]  hyst, cycles;
  logic        [12:0] bemf;
  int                 err_count;
  int                 num_checks;

  localparam logic [13:0] DUTY [8] = '{14'h0000, 14'h1388, 14'h1D4C, 14'h20B7,
                                      14'h222E, 14'h249F, 14'h2616, 14'h26AC};
  localparam logic [7:0]  NEG [8]  = '{8'h00, 8'hD8, 8'hE2, 8'hEC,
                                      8'hF6, 8'h0A, 8'h14, 8'h1E};
  localparam logic [3:0]  ANG [4]  = '{4'h5, 4'h8, 4'hC, 4'hF};

  tac_config_bank DUT (
    .CLK(CLK), .RESETN(RESETN), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TRI_DUTY_S3(duty[0]), .TRI_DUTY_S4(duty[1]),
    .TRI_DUTY_S5(duty[2]), .TRI_DUTY_S6(duty[3]), .TRI_DUTY_S7(duty[4]),
    .WIDE_MOD_ANGLE_ADVANCE(adv), .OPEN_LOOP_HANDOVER_COUNT(handover),
    .SURGE_GUARD_NEGATIVE_LIMIT(neg), .SURGE_GUARD_POSITIVE_LIMIT(pos),
    .SURGE_GUARD_HYSTERESIS(hyst), .INITIAL_SPEED_BACKEMF_THRESHOLD(bemf),
    .INITIAL_SPEED_CYCLE_THRESHOLD(cycles), .OPEN_LOOP_CROSSING_ANGLE(angle),
    .QUICK_LAUNCH_RATE_DIVIDER(divider));

  always #4 CLK = ~CLK;

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Answer taken at the rising edge that samples ready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] exp, input logic experr);
    int n;
    n = 0;
    @(posedge CLK);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge CLK);
    penable <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 16) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 16) begin
      err_count++;
      final_report();
    end
    if (!wr) chk(PRDATA, exp, "read data");
    chk({31'h0, PSLVERR}, {31'h0, experr}, "slave error");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(negedge CLK);
  endtask

  task automatic reset_chk();
    apb(1'b0, tac_pkg::PROFILE_ADDR, 32'h0, 4'h0, tac_pkg::PROFILE_RESET, 1'b0);
    apb(1'b0, tac_pkg::CFG_ONE_ADDR, 32'h0, 4'h0, tac_pkg::CFG_ONE_RESET, 1'b0);
    chk(32'(hyst), 32'h14, "hysteresis at reset");
    chk(32'(pos), 32'h14, "positive limit at reset");
    chk(32'(cycles), 32'h2, "cycles at reset");
    chk(32'(angle), 32'h5, "angle at reset");
    chk(32'(divider), 32'h1, "divider at reset");
    chk(32'(duty[0]), 32'h0, "duty at reset");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] w;
    logic [31:0] pw;
    logic [2:0]  ng, cy;
    logic [1:0]  an;
    logic        hy;
    logic [4:0]  bm;
    CLK = 1'b0;
    RESETN = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    err_count = 0;
    num_checks = 0;
    repeat (6) @(posedge CLK);
    RESETN <= 1'b1;
    reset_chk();
    for (int i = 0; i < 8; i++) begin
      w = 32'h0;
      for (int k = 0; k < 5; k++) w[19 - 3 * k +: 3] = 3'((i + k) % 8);
      w[6:5] = 2'(i);
      w[4:0] = 5'(i * 5);
      w[31]  = i[0];
      apb(1'b1, tac_pkg::PROFILE_ADDR, w, 4'hF, 32'h0, 1'b0);
      settle();
      for (int k = 0; k < 5; k++) chk(32'(duty[k]), 32'(DUTY[(i + k) % 8]), "duty");
      chk(32'(adv), 32'(5 * (i % 4)), "advance");
      apb(1'b0, tac_pkg::PROFILE_ADDR, 32'h0, 4'h0, w, 1'b0);
      pw = w;
    end
    for (int i = 0; i < 8; i++) begin
      ng = 3'(i);
      hy = i[0];
      bm = 5'(i * 4 + 3);
      cy = 3'(7 - i);
      an = 2'(i);
      w = i[0] ? 32'h7F380070 : 32'h0;
      w[31] = i[2];
      w[23:22] = 2'(i + 1);
      w[18:16] = ng;
      w[15] = hy;
      w[14:10] = bm;
      w[9:7] = cy;
      w[3:2] = an;
      w[1:0] = ~an;
      apb(1'b1, tac_pkg::CFG_ONE_ADDR, w, 4'hF, 32'h0, 1'b0);
      settle();
      chk(32'(neg), 32'(signed'(NEG[ng])), "negative limit");
      chk(32'(hyst), hy ? 32'hA : 32'h14, "hysteresis");
      chk(32'(pos), 32'(signed'(NEG[ng] + (hy ? 8'h0A : 8'h14))), "positive limit");
      chk(32'(bemf), 32'(200 * bm), "back-emf threshold");
      chk(32'(cycles), 32'(2 + 3 * cy), "cycle threshold");
      chk(32'(angle), 32'(ANG[an]), "crossing angle");
      chk(32'(divider), 32'(1 << (~an)), "rate divider");
      chk(32'(handover), 32'(w[23:22]), "handover count");
      apb(1'b0, tac_pkg::CFG_ONE_ADDR, 32'h0, 4'h0, w, 1'b0);
    end
    // Byte strobes and an empty strobe leave other bytes alone
    apb(1'b1, tac_pkg::PROFILE_ADDR, 32'hFFFFFFFF, 4'h4, 32'h0, 1'b0);
    apb(1'b1, tac_pkg::PROFILE_ADDR, 32'h0, 4'h0, 32'h0, 1'b0);
    apb(1'b0, tac_pkg::PROFILE_ADDR, 32'h0, 4'h0, pw | 32'h00FF0000, 1'b0);
    // Unmapped slot between the two words is refused
    apb(1'b1, 12'h264, 32'hFFFFFFFF, 4'hF, 32'h0, 1'b1);
    apb(1'b0, 12'h264, 32'h0, 4'h0, tac_pkg::UNMAPPED_READ, 1'b1);
    apb(1'b0, tac_pkg::CFG_ONE_ADDR, 32'h0, 4'h0, w, 1'b0);
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    reset_chk();
    final_report();
  end
endmodule // tb_top

`default_nettype wire
